// ---- include/nvc_map.svh ----
// register indices, field positions, reset values and timing counts
// assumes: included by bare name after the package, once per file
`ifndef NVC_MAP_SVH
`define NVC_MAP_SVH

`define NVC_BYTES          512
`define NVC_AW             9
`define NVC_LAST_ADDR      9'h1ff
// apb byte address = 4 * index; paddr[11:10] selects the access kind
`define NVC_RGN_IO         2'h0
`define NVC_RGN_DATA       2'h1
`define NVC_RGN_BIT        2'h2
`define NVC_IO_LAST        8'h3f
`define NVC_BIT_LAST       8'h1f
`define NVC_EXT_FIRST      8'h60
`define NVC_IO_TO_DATA     8'h20
// data-space indices of the registers
`define NVC_IDX_GPREG0     8'h3e
`define NVC_IDX_CONTROL    8'h3f
`define NVC_IDX_DATA       8'h40
`define NVC_IDX_ADDR_LO    8'h41
`define NVC_IDX_ADDR_HI    8'h42
`define NVC_IDX_GPREG1     8'h4a
`define NVC_IDX_GPREG2     8'h4b
// control register fields
`define NVC_CTL_READ       0
`define NVC_CTL_WRITE      1
`define NVC_CTL_ARM        2
`define NVC_CTL_RIE        3
`define NVC_GP_RESET       8'h00
`define NVC_DATA_RESET     8'h00
`define NVC_ADDR_RESET     9'h000
// timing
`define NVC_CLK_NS         25
`define NVC_WR_OSC_CYC     27072
`define NVC_WR_TIME_NS     3300000
`define NVC_WR_CYCLES      (`NVC_WR_TIME_NS / `NVC_CLK_NS)
`define NVC_ARM_CYCLES     3'h4
`define NVC_RD_STALL       3'h4
`define NVC_WR_STALL       3'h2
`define NVC_CNT_W          18

`endif

// ---- include/nvc_pkg.sv ----
// types shared by the byte-access controller and its leaves
// assumes: compiled before all design files
package nvc_pkg;
	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] data;
	} nvc_wr_t;

	typedef enum logic [1:0] {
		NVC_IDLE,
		NVC_WAIT,
		NVC_DONE
	} nvc_apb_st_t;
endpackage

// ---- verilog/nvc_gp_regs.sv ----
// three general purpose byte registers with per-bit write mask
// assumes: top decodes the address and masks bit operations
`include "nvc_map.svh"
module nvc_gp_regs
	import nvc_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [2:0]       we,
	input  wire logic [7:0]       wbyte,
	input  wire logic [7:0]       wmask,
	output logic      [2:0][7:0]  q
);
	logic [2:0][7:0] gp_ff;

	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_reg
			always_ff @(posedge clk) begin
				if (!resetn)
					gp_ff[i] <= `NVC_GP_RESET;
				else if (we[i])
					gp_ff[i] <= (gp_ff[i] & ~wmask) | (wbyte & wmask);
			end
		end
	endgenerate

	assign q = gp_ff;
endmodule

// ---- verilog/nvc_array.sv ----
// 512-byte store with self-timed byte write
// assumes: por_n drops only on inadequate supply; resetn is not seen here
`include "nvc_map.svh"
module nvc_array
	import nvc_pkg::*;
#(
	parameter int unsigned WR_CYCLES = `NVC_WR_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        por_n,
	input  wire logic        start,
	input  wire nvc_wr_t     wr,
	input  wire logic [8:0]  rd_addr,
	output logic      [7:0]  rd_data,
	output logic             busy
);
	localparam logic [`NVC_CNT_W-1:0] LAST =
		`NVC_CNT_W'(WR_CYCLES - 1);

	logic [7:0]            mem_ff [`NVC_BYTES];
	nvc_wr_t               hold_ff;
	logic                  busy_ff;
	logic [`NVC_CNT_W-1:0] cnt_ff;

	// kept apart from the core reset so a write survives it
	always_ff @(posedge clk) begin
		if (!por_n) begin
			busy_ff <= 1'b0;
			cnt_ff  <= '0;
		end else if (start && !busy_ff) begin
			busy_ff <= 1'b1;
			cnt_ff  <= '0;
		end else if (busy_ff) begin
			cnt_ff <= cnt_ff + 1'b1;
			if (cnt_ff == LAST)
				busy_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (start && !busy_ff)
			hold_ff <= wr;
	end

	always_ff @(posedge clk) begin
		if (por_n && busy_ff && cnt_ff == LAST)
			mem_ff[hold_ff.addr] <= hold_ff.data;
	end

	assign rd_data = mem_ff[rd_addr];
	assign busy    = busy_ff;

	hold_stable_a: assert property (@(posedge clk) disable iff (!por_n)
		busy_ff && $past(busy_ff) |-> $stable(hold_ff))
		else $error("write target changed during write");
	self_clear_a: assert property (@(posedge clk) disable iff (!por_n)
		busy_ff && cnt_ff == LAST |=> !busy_ff)
		else $error("write did not end at its time");
endmodule

// ---- verilog/nvc_ctrl.sv ----
// byte-access controller for the 512-byte data store, apb slave
// assumes: apb master per amba apb; self_program_active from self-programming;
// por_n high while supply is adequate
`include "nvc_map.svh"
module nvc_ctrl
	import nvc_pkg::*;
#(
	parameter int unsigned WR_CYCLES = `NVC_WR_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        por_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        self_program_active,
	input  wire logic        global_irq_en,
	input  wire logic        sleep_power_down,
	output logic             nv_ready_irq,
	output logic             clk_keep_running
);
	nvc_apb_st_t     st_ff;
	logic [2:0]      stall_ff;
	logic [31:0]     prdata_ff;
	logic            pready_ff;
	logic            pslverr_ff;
	logic            irq_ff;
	logic            keep_ff;
	logic [8:0]      nv_byte_address_ff;
	logic [7:0]      nv_byte_data_ff;
	logic            nv_master_write_arm_ff;
	logic [2:0]      arm_cnt_ff;
	logic            nv_ready_irq_enable_ff;

	logic [1:0]      rgn;
	logic [7:0]      idx;
	logic [7:0]      daddr;
	logic            mapped;
	logic            bitop;
	logic [7:0]      wbyte;
	logic [7:0]      wmask;
	logic [7:0]      rbyte;
	logic            commit;
	logic            wr_en;
	logic            busy;
	logic            rd_go;
	logic            wr_go;
	logic            rd_hit;
	logic            wr_hit;
	logic            rd_acc_ff;
	logic            wr_acc_ff;
	logic [7:0]      rd_data;
	logic [2:0]      gp_we;
	logic [2:0][7:0] gp_q;
	nvc_wr_t         wr_req;

	// address decode: io, data-space and bit-operation views
	always_comb begin
		rgn    = paddr[11:10];
		idx    = paddr[9:2];
		bitop  = 1'b0;
		daddr  = 8'h00;
		mapped = 1'b0;
		case (rgn)
			`NVC_RGN_IO: begin
				daddr  = idx + `NVC_IO_TO_DATA;
				mapped = (idx <= `NVC_IO_LAST);
			end
			`NVC_RGN_DATA: begin
				daddr  = idx;
				mapped = (idx >= `NVC_IO_TO_DATA);
			end
			`NVC_RGN_BIT: begin
				daddr  = idx + `NVC_IO_TO_DATA;
				mapped = (idx <= `NVC_BIT_LAST);
				bitop  = 1'b1;
			end
			default: begin
				daddr  = 8'h00;
				mapped = 1'b0;
			end
		endcase
		case (daddr)
			`NVC_IDX_GPREG0, `NVC_IDX_CONTROL, `NVC_IDX_DATA,
			`NVC_IDX_ADDR_LO, `NVC_IDX_ADDR_HI, `NVC_IDX_GPREG1,
			`NVC_IDX_GPREG2: ;
			default: mapped = 1'b0;
		endcase
	end

	// bit operation: pwdata[2:0] selects the bit, pwdata[3] its value
	always_comb begin
		if (bitop) begin
			wmask = 8'h01 << pwdata[2:0];
			wbyte = {8{pwdata[3]}} & wmask;
		end else begin
			wmask = 8'hff;
			wbyte = pwdata[7:0];
		end
	end

	always_comb begin
		case (daddr)
			`NVC_IDX_GPREG0:  rbyte = gp_q[0];
			`NVC_IDX_GPREG1:  rbyte = gp_q[1];
			`NVC_IDX_GPREG2:  rbyte = gp_q[2];
			`NVC_IDX_DATA:    rbyte = nv_byte_data_ff;
			`NVC_IDX_ADDR_LO: rbyte = nv_byte_address_ff[7:0];
			`NVC_IDX_ADDR_HI: rbyte = {7'h00, nv_byte_address_ff[8]};
			`NVC_IDX_CONTROL: rbyte = {4'h0, nv_ready_irq_enable_ff,
				nv_master_write_arm_ff, busy, 1'b0};
			default:          rbyte = 8'h00;
		endcase
	end

	assign commit = psel && penable && pready_ff;
	assign wr_en  = commit && pwrite && mapped;
	assign rd_hit = pwrite && mapped && daddr == `NVC_IDX_CONTROL
		&& wmask[`NVC_CTL_READ] && wbyte[`NVC_CTL_READ]
		&& !busy;
	assign wr_hit = pwrite && mapped && daddr == `NVC_IDX_CONTROL
		&& wmask[`NVC_CTL_WRITE] && wbyte[`NVC_CTL_WRITE]
		&& nv_master_write_arm_ff && !busy
		&& !self_program_active;
	// judged on the first access cycle: the arm may lapse during the stall
	assign rd_go  = commit && rd_acc_ff;
	assign wr_go  = commit && wr_acc_ff;
	assign wr_req = '{addr: nv_byte_address_ff, data: nv_byte_data_ff};

	always_comb begin
		gp_we    = 3'h0;
		gp_we[0] = wr_en && daddr == `NVC_IDX_GPREG0;
		gp_we[1] = wr_en && daddr == `NVC_IDX_GPREG1;
		gp_we[2] = wr_en && daddr == `NVC_IDX_GPREG2;
	end

	// apb handshake; stall length judged on the first access cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_ff      <= NVC_IDLE;
			stall_ff   <= 3'h0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			rd_acc_ff  <= 1'b0;
			wr_acc_ff  <= 1'b0;
		end else begin
			case (st_ff)
				NVC_IDLE: begin
					if (psel && penable) begin
						st_ff     <= NVC_WAIT;
						rd_acc_ff <= rd_hit;
						wr_acc_ff <= wr_hit;
						if (rd_hit)
							stall_ff <= `NVC_RD_STALL;
						else if (wr_hit)
							stall_ff <= `NVC_WR_STALL;
						else
							stall_ff <= 3'h0;
					end
				end
				NVC_WAIT: begin
					if (stall_ff == 3'h0) begin
						st_ff      <= NVC_DONE;
						pready_ff  <= 1'b1;
						pslverr_ff <= !mapped;
						prdata_ff  <= {24'h000000, rbyte};
					end else begin
						stall_ff <= stall_ff - 3'h1;
					end
				end
				NVC_DONE: begin
					st_ff      <= NVC_IDLE;
					pready_ff  <= 1'b0;
					pslverr_ff <= 1'b0;
					rd_acc_ff  <= 1'b0;
					wr_acc_ff  <= 1'b0;
				end
				default: st_ff <= NVC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			nv_byte_address_ff <= `NVC_ADDR_RESET;
		end else if (wr_en && !busy) begin
			if (daddr == `NVC_IDX_ADDR_LO)
				nv_byte_address_ff[7:0] <= (nv_byte_address_ff[7:0]
					& ~wmask) | (wbyte & wmask);
			else if (daddr == `NVC_IDX_ADDR_HI && wmask[0])
				nv_byte_address_ff[8] <= wbyte[0];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			nv_byte_data_ff <= `NVC_DATA_RESET;
		else if (rd_go)
			nv_byte_data_ff <= rd_data;
		else if (wr_en && daddr == `NVC_IDX_DATA)
			nv_byte_data_ff <= (nv_byte_data_ff & ~wmask)
				| (wbyte & wmask);
	end

	// arm window: four cycles from the last arm write, then gone
	always_ff @(posedge clk) begin
		if (!resetn) begin
			nv_master_write_arm_ff <= 1'b0;
			arm_cnt_ff             <= 3'h0;
		end else if (wr_en && daddr == `NVC_IDX_CONTROL
				&& wmask[`NVC_CTL_ARM] && wbyte[`NVC_CTL_ARM]) begin
			nv_master_write_arm_ff <= 1'b1;
			arm_cnt_ff             <= `NVC_ARM_CYCLES;
		end else if (nv_master_write_arm_ff) begin
			arm_cnt_ff <= arm_cnt_ff - 3'h1;
			if (arm_cnt_ff == 3'h1)
				nv_master_write_arm_ff <= 1'b0;
			if (wr_en && daddr == `NVC_IDX_CONTROL
					&& wmask[`NVC_CTL_ARM])
				nv_master_write_arm_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			nv_ready_irq_enable_ff <= 1'b0;
		else if (wr_en && daddr == `NVC_IDX_CONTROL
				&& wmask[`NVC_CTL_RIE])
			nv_ready_irq_enable_ff <= wbyte[`NVC_CTL_RIE];
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_ff  <= 1'b0;
			keep_ff <= 1'b0;
		end else begin
			irq_ff  <= nv_ready_irq_enable_ff && global_irq_en
				&& !busy;
			keep_ff <= sleep_power_down && busy;
		end
	end

	nvc_array #(
		.WR_CYCLES (WR_CYCLES)
	) u_array (
		.clk     (clk),
		.por_n   (por_n),
		.start   (wr_go),
		.wr      (wr_req),
		.rd_addr (nv_byte_address_ff),
		.rd_data (rd_data),
		.busy    (busy)
	);

	nvc_gp_regs u_gp (
		.clk    (clk),
		.resetn (resetn),
		.we     (gp_we),
		.wbyte  (wbyte),
		.wmask  (wmask),
		.q      (gp_q)
	);

	assign prdata           = prdata_ff;
	assign pready           = pready_ff;
	assign pslverr          = pslverr_ff;
	assign nv_ready_irq     = irq_ff;
	assign clk_keep_running = keep_ff;

	arm_expiry_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(nv_master_write_arm_ff) |-> ##4 !nv_master_write_arm_ff)
		else $error("arm window not four cycles");
	read_stall_a: assert property (@(posedge clk) disable iff (!resetn)
		st_ff == NVC_IDLE && psel && penable && pwrite
		&& mapped && daddr == `NVC_IDX_CONTROL && wmask[0] && wbyte[0]
		&& !busy |-> !pready_ff [*6] ##1 pready_ff)
		else $error("read strobe stall wrong");
	write_stall_a: assert property (@(posedge clk) disable iff (!resetn)
		st_ff == NVC_IDLE && psel && penable && stall_ff == 3'h0
		&& pwrite && mapped && daddr == `NVC_IDX_CONTROL && wmask[1]
		&& wbyte[1] && !wbyte[0] && nv_master_write_arm_ff && !busy
		&& !self_program_active
		|-> !pready_ff [*4] ##1 pready_ff)
		else $error("write strobe stall wrong");
	no_write_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(busy) |-> $past(nv_master_write_arm_ff, 5)
		&& !$past(self_program_active, 5))
		else $error("write started without arm");
	addr_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		busy && $past(busy) |-> $stable(nv_byte_address_ff))
		else $error("address changed during write");
	read_fetch_a: assert property (@(posedge clk) disable iff (!resetn)
		rd_go |=> nv_byte_data_ff == $past(rd_data))
		else $error("read byte not loaded");
	ready_irq_a: assert property (@(posedge clk) disable iff (!resetn)
		nv_ready_irq_enable_ff && global_irq_en && !busy
		|=> nv_ready_irq)
		else $error("ready interrupt missing");
	addr_hi_zero_a: assert property (@(posedge clk) disable iff (!resetn)
		commit && !pwrite && mapped && daddr == `NVC_IDX_ADDR_HI
		|-> prdata_ff[31:1] == 31'h0)
		else $error("upper address bits not zero");
	bit_only_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_en && bitop && daddr == `NVC_IDX_GPREG0
		|=> ((gp_q[0] ^ $past(gp_q[0])) & ~$past(wmask))
		== 8'h00)
		else $error("bit operation touched other bits");
	irq_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
		!global_irq_en || busy |=> !nv_ready_irq)
		else $error("ready interrupt while busy or masked");
endmodule

// ---- bench/nvc_core_model.sv ----
// core model: apb master issuing the core's register accesses
// assumes: each task is entered just after a rising clock edge
module nvc_core_model (
	input  wire logic        clk,
	input  wire logic        self_program_active,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// hold leaves psel up so a setup cycle can follow at once
	task automatic xfer(input logic [11:0] a, input logic w,
		input logic [31:0] d, input logic hold, output logic [31:0] q);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		if (!hold) begin
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic wait_idle(output logic ok);
		logic [31:0] q;
		ok = 1'b0;
		for (int i = 0; i < 200 && !ok; i++) begin
			xfer({2'h1, 8'h3f, 2'h0}, 1'b0, 32'h0, 1'b0, q);
			ok = !q[1] && !self_program_active;
		end
	endtask
endmodule

// ---- bench/nvc_ctrl_tb.sv ----
// self-checking bench for the byte-access controller
// assumes: design and core model compiled before this file
`include "nvc_map.svh"
module nvc_ctrl_tb
	import nvc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned WR_CYC = 20;
	localparam logic [7:0] CTL = `NVC_IDX_CONTROL;
	localparam logic [7:0] DAT = `NVC_IDX_DATA;
	localparam logic [7:0] LO = `NVC_IDX_ADDR_LO;
	localparam logic [7:0] HI = `NVC_IDX_ADDR_HI;
	typedef struct {logic w; logic [7:0] d; logic e; int c;} nvc_note_t;
	logic clk = 1'b0, resetn = 1'b0, por_n = 1'b0;
	logic self_program_active = 1'b0, global_irq_en = 1'b0;
	logic sleep_power_down = 1'b0, ok;
	logic psel, penable, pwrite, pready, pslverr, nv_ready_irq;
	logic clk_keep_running;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] v, dv [3];
	logic [8:0] av [3];
	logic [7:0] ix [7] = '{8'h3e, 8'h4a, 8'h4b, CTL, DAT, LO, HI};
	nvc_note_t notes[$], nt;
	int err_total = 0, tests_run = 0, acc = 0, cyc_cnt = 0;

	always #12.5 clk = ~clk;

	nvc_ctrl #(.WR_CYCLES(WR_CYC)) i_dut (.clk(clk), .resetn(resetn),
		.por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .self_program_active(self_program_active),
		.global_irq_en(global_irq_en), .sleep_power_down(sleep_power_down),
		.nv_ready_irq(nv_ready_irq), .clk_keep_running(clk_keep_running));
	nvc_core_model i_core (.clk(clk), .self_program_active(self_program_active),
		.prdata(prdata), .pready(pready), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic cmp_data(input logic [31:0] g, input logic [31:0] x);
		chk(g, x);
	endtask
	task automatic cmp_bit(input logic g, input logic x);
		chk({31'h0, g}, {31'h0, x});
	endtask
	task automatic cmp_cyc(input int g, input int x);
		chk(32'(g), 32'(x));
	endtask
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// the monitor pairs each answer with the oldest note
	always @(posedge clk) begin
		if (psel === 1'b1 && penable === 1'b1) begin
			acc = acc + 1;
			if (pready === 1'b1 && notes.size() > 0) begin
				nt = notes.pop_front();
				if (!nt.w)
					cmp_data(prdata, {24'h0, nt.d});
				cmp_bit(pslverr, nt.e);
				cmp_cyc(acc, nt.c);
			end
			if (pready === 1'b1)
				acc = 0;
		end
	end
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_total++;
			finish_test();
		end
	end

	task automatic go(input logic [1:0] rg, input logic [7:0] x,
		input logic w, input logic [7:0] d, input logic e, input int c,
		input logic hold);
		logic [31:0] q;
		notes.push_back('{w, d, e, c});
		i_core.xfer({rg, x, 2'h0}, w, {24'h0, d}, hold, q);
	endtask
	task automatic wr(input logic [7:0] x, input logic [7:0] d);
		go(2'h1, x, 1'b1, d, 1'b0, 3, 1'b0);
	endtask
	task automatic rd(input logic [7:0] x, input logic [7:0] d);
		go(2'h1, x, 1'b0, d, 1'b0, 3, 1'b0);
	endtask
	task automatic store(input logic [8:0] a, input logic [7:0] d);
		global_irq_en <= 1'b0;
		i_core.wait_idle(ok);
		cmp_bit(ok, 1'b1);
		wr(LO, a[7:0]);
		wr(HI, {7'h0, a[8]});
		wr(DAT, d);
		go(2'h1, CTL, 1'b1, 8'h04, 1'b0, 3, 1'b1);
		go(2'h1, CTL, 1'b1, 8'h02, 1'b0, 5, 1'b0);
	endtask
	task automatic load(input logic [8:0] a, input logic [7:0] d);
		i_core.wait_idle(ok);
		cmp_bit(ok, 1'b1);
		wr(LO, a[7:0]);
		wr(HI, {7'h0, a[8]});
		go(2'h1, CTL, 1'b1, 8'h01, 1'b0, 7, 1'b0);
		rd(DAT, d);
	endtask
	task automatic endt(input string s);
		$display("test %s done", s);
	endtask

	initial begin
		void'($urandom(32'hece62089));
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		por_n <= 1'b1;
		@(posedge clk);
		foreach (ix[i])
			rd(ix[i], 8'h00);
		endt("reset");
		for (int i = 0; i < 3; i++) begin
			v = 8'($urandom);
			go(2'h0, ix[i] - 8'h20, 1'b1, v, 1'b0, 3, 1'b0);
			rd(ix[i], v);
		end
		go(2'h1, 8'h60, 1'b0, 8'h00, 1'b1, 3, 1'b0);
		endt("views");
		v = 8'($urandom);
		wr(8'h3e, v);
		// one bit at a time, the rest of the byte must survive
		for (int b = 0; b < 8; b++) begin
			v[b] = 1'($urandom);
			go(2'h2, 8'h1e, 1'b1, {4'h0, v[b], 3'(b)}, 1'b0, 3, 1'b0);
		end
		go(2'h2, 8'h1e, 1'b0, v, 1'b0, 3, 1'b0);
		go(2'h2, 8'h2a, 1'b1, 8'h08, 1'b1, 3, 1'b0);
		wr(HI, 8'hfe);
		rd(HI, 8'h00);
		endt("bits");
		for (int i = 0; i < 3; i++) begin
			av[i] = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff
				: 9'($urandom_range(510, 1));
			dv[i] = 8'($urandom);
			store(av[i], dv[i]);
			rd(CTL, 8'h02);
			go(2'h1, CTL, 1'b1, 8'h01, 1'b0, 3, 1'b0);
			wr(LO, ~av[i][7:0]);
			rd(LO, av[i][7:0]);
		end
		for (int i = 0; i < 3; i++)
			load(av[i], dv[i]);
		endt("store");
		wr(CTL, 8'h04);
		repeat (6) @(posedge clk);
		go(2'h1, CTL, 1'b1, 8'h02, 1'b0, 3, 1'b0);
		rd(CTL, 8'h00);
		self_program_active <= 1'b1;
		go(2'h1, CTL, 1'b1, 8'h04, 1'b0, 3, 1'b1);
		go(2'h1, CTL, 1'b1, 8'h02, 1'b0, 3, 1'b0);
		rd(CTL, 8'h00);
		self_program_active <= 1'b0;
		endt("refuse");
		v = 8'($urandom);
		store(9'h0a5, v);
		sleep_power_down <= 1'b1;
		repeat (2) @(posedge clk);
		cmp_bit(clk_keep_running, 1'b1);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(CTL, 8'h02);
		sleep_power_down <= 1'b0;
		load(9'h0a5, v);
		wr(CTL, 8'h08);
		global_irq_en <= 1'b1;
		repeat (3) @(posedge clk);
		cmp_bit(nv_ready_irq, 1'b1);
		global_irq_en <= 1'b0;
		repeat (3) @(posedge clk);
		cmp_bit(nv_ready_irq, 1'b0);
		endt("reset_power_irq");
		finish_test();
	end
endmodule
